// ===== hw/cttm_exec_mem.sv
// Executed-instruction bit memory with one bit per code address.
`timescale 1ns/10ps
module cttm_exec_mem (
	input wire logic clock,
	input wire logic rst,
	input wire logic set_en,
	input wire cttm_pkg::cttm_addr_t set_addr,
	input wire logic wr_en,
	input wire cttm_pkg::cttm_addr_t wr_addr,
	input wire logic wr_bit,
	input wire cttm_pkg::cttm_addr_t rd_addr,
	output logic rd_bit_q
);

	logic mem [cttm_pkg::MEM_DEPTH];

	// Contents are left alone by reset so coverage survives a core restart.
	// A host write in the same cycle as a core mark wins, as it was issued later.
	always_ff @(posedge clock) begin
		if (set_en && !(wr_en && wr_addr == set_addr)) begin
			mem[set_addr] <= 1'b1;
		end
		if (wr_en) begin
			mem[wr_addr] <= wr_bit;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_bit_q <= 1'b0;
		end else begin
			rd_bit_q <= mem[rd_addr];
		end
	end

endmodule

// ===== hw/cttm_monitor.sv
// Cycle counter with start/stop triggers and executed-address coverage bits.
`timescale 1ns/10ps

// Behaviour
// - Count only during a run when gated on.
// - Single start address begins counting when executed.
// - Start range begins counting on any address inside.
// - Free start begins counting with the run.
// - Omitted start value keeps previous start setting.
// - Single stop address ends counting when executed.
// - Stop range ends counting on any address inside.
// - Free stop counts until the run ends.
// - The stop-match cycle is not counted.
// - Free stop also counts the break cycle.
// - Cleared triggers never start the counter.
// - Clear request clears both triggers, shown on readback.
// - Start and stop settings apply together.
// - One coverage bit per code address.
// - Read one address, a range, or everything.
// - Write 0 or 1 in request order.
// - Whole-memory write without value clears all bits.
// - Overlapping writes each apply fully, later wins.
// - 32-bit loadable counter; wrap raises overflow.
module cttm_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic cyc_strobe,
	input wire cttm_pkg::cttm_addr_t pc,
	input wire logic cmd_valid,
	input wire cttm_pkg::cttm_op_e cmd_op,
	input wire cttm_pkg::cttm_addr_t cmd_lo,
	input wire cttm_pkg::cttm_addr_t cmd_hi,
	input wire cttm_pkg::cttm_trig_e cmd_start_mode,
	input wire logic cmd_start_keep,
	input wire cttm_pkg::cttm_trig_e cmd_stop_mode,
	input wire logic cmd_stop_keep,
	input wire cttm_pkg::cttm_addr_t cmd_stop_lo,
	input wire cttm_pkg::cttm_addr_t cmd_stop_hi,
	input wire logic cmd_all,
	input wire logic cmd_bit,
	input wire logic cmd_bit_given,
	input wire cttm_pkg::cttm_cnt_t cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output cttm_pkg::cttm_addr_t rsp_addr,
	output logic rsp_bit,
	output logic rsp_last,
	output cttm_pkg::cttm_cnt_t cycle_count,
	output logic overflow,
	output logic counting,
	output cttm_pkg::cttm_trig_e start_mode,
	output cttm_pkg::cttm_addr_t start_lo,
	output cttm_pkg::cttm_addr_t start_hi,
	output cttm_pkg::cttm_trig_e stop_mode,
	output cttm_pkg::cttm_addr_t stop_lo,
	output cttm_pkg::cttm_addr_t stop_hi
);

	////////////////////////////////////////////////////////////////////////////////

	logic accept;
	logic set_fire;
	logic clear_fire;
	logic load_fire;
	logic bits_fire;
	logic start_match;
	logic stop_match;
	logic start_fire;
	logic stop_hit;
	logic run_cycle;
	logic inc_en;
	logic armed_q;
	logic counting_q;
	logic counting_d;
	logic ready_q;
	logic rsp_valid_q;
	logic rsp_last_q;
	logic wbit_q;
	cttm_pkg::cttm_cnt_t count_q;
	cttm_pkg::cttm_cnt_t count_d;
	logic overflow_q;
	cttm_pkg::cttm_seq_e seq_q;
	cttm_pkg::cttm_addr_t cur_q;
	cttm_pkg::cttm_addr_t end_q;
	cttm_pkg::cttm_addr_t rsp_addr_q;
	cttm_pkg::cttm_addr_t bit_lo;
	cttm_pkg::cttm_addr_t bit_hi;

	assign accept = cmd_valid && ready_q;
	assign set_fire = accept && (cmd_op == cttm_pkg::OP_SET_TRIG);
	assign clear_fire = accept && (cmd_op == cttm_pkg::OP_CLEAR_TRIG);
	assign load_fire = accept && (cmd_op == cttm_pkg::OP_LOAD_CNT);
	assign bits_fire = accept && ((cmd_op == cttm_pkg::OP_READ_BITS) ||
		(cmd_op == cttm_pkg::OP_WRITE_BITS));

	////////////////////////////////////////////////////////////////////////////////
	// Triggers. Both halves load on the same accepted command, so the core never
	// sees a new start paired with an old stop.

	cttm_trigger #(
		.RESET_MODE(cttm_pkg::START_RESET)
	) u_start (
		.clock(clock),
		.rst(rst),
		.load(set_fire),
		.keep(cmd_start_keep),
		.clear(clear_fire),
		.mode_in(cmd_start_mode),
		.lo_in(cmd_lo),
		.hi_in(cmd_hi),
		.pc(pc),
		.mode_q(start_mode),
		.lo_q(start_lo),
		.hi_q(start_hi),
		.hit(start_match)
	);

	cttm_trigger #(
		.RESET_MODE(cttm_pkg::STOP_RESET)
	) u_stop (
		.clock(clock),
		.rst(rst),
		.load(set_fire),
		.keep(cmd_stop_keep),
		.clear(clear_fire),
		.mode_in(cmd_stop_mode),
		.lo_in(cmd_stop_lo),
		.hi_in(cmd_stop_hi),
		.pc(pc),
		.mode_q(stop_mode),
		.lo_q(stop_lo),
		.hi_q(stop_hi),
		.hit(stop_match)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Gating. Free start fires once per run, on its first machine cycle; address
	// starts may fire again after a stop within the same run.

	assign run_cycle = run && cyc_strobe;

	always_comb begin
		case (start_mode)
			cttm_pkg::TRIG_SINGLE: start_fire = start_match;
			cttm_pkg::TRIG_RANGE: start_fire = start_match;
			cttm_pkg::TRIG_FREE: start_fire = armed_q;
			default: start_fire = 1'b0;
		endcase
	end

	// A free or cleared stop never matches, so counting lasts to the end of the
	// run and the break cycle is still counted.
	assign stop_hit = stop_match;

	assign inc_en = run_cycle && !stop_hit && (counting_q || start_fire);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b1;
		end else if (!run) begin
			armed_q <= 1'b1;
		end else if (cyc_strobe) begin
			armed_q <= 1'b0;
		end
	end

	always_comb begin
		counting_d = counting_q;
		if (!run) begin
			counting_d = 1'b0;
		end else if (cyc_strobe) begin
			if (stop_hit) begin
				counting_d = 1'b0;
			end else if (start_fire) begin
				counting_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			counting_q <= 1'b0;
		end else begin
			counting_q <= counting_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter. A host load wins over an increment in the same cycle.

	assign count_d = count_q + cttm_pkg::CNT_ONE;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= cttm_pkg::CNT_RESET;
			overflow_q <= 1'b0;
		end else if (load_fire) begin
			count_q <= cmd_data;
			overflow_q <= 1'b0;
		end else if (inc_en) begin
			count_q <= count_d;
			if (count_q == cttm_pkg::CNT_MAX) begin
				overflow_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit memory sequencer. One address per clock; the host is held off until a
	// sweep ends, so requests apply strictly in order and each one in full.

	assign bit_lo = cmd_all ? cttm_pkg::ADDR_FIRST : cmd_lo;
	assign bit_hi = cmd_all ? cttm_pkg::ADDR_LAST : ((cmd_hi < cmd_lo) ? cmd_lo : cmd_hi);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seq_q <= cttm_pkg::SEQ_IDLE;
			ready_q <= 1'b1;
			cur_q <= cttm_pkg::ADDR_FIRST;
			end_q <= cttm_pkg::ADDR_FIRST;
			wbit_q <= 1'b0;
		end else begin
			case (seq_q)
				cttm_pkg::SEQ_IDLE: begin
					if (bits_fire) begin
						seq_q <= (cmd_op == cttm_pkg::OP_READ_BITS) ?
							cttm_pkg::SEQ_READ : cttm_pkg::SEQ_WRITE;
						ready_q <= 1'b0;
						cur_q <= bit_lo;
						end_q <= bit_hi;
						wbit_q <= cmd_bit_given ? cmd_bit : 1'b0;
					end
				end
				cttm_pkg::SEQ_READ, cttm_pkg::SEQ_WRITE: begin
					if (cur_q == end_q) begin
						seq_q <= cttm_pkg::SEQ_IDLE;
						ready_q <= 1'b1;
					end else begin
						cur_q <= cur_q + cttm_pkg::ADDR_STEP;
					end
				end
				default: begin
					seq_q <= cttm_pkg::SEQ_IDLE;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsp_valid_q <= 1'b0;
			rsp_last_q <= 1'b0;
			rsp_addr_q <= cttm_pkg::ADDR_FIRST;
		end else begin
			rsp_valid_q <= (seq_q == cttm_pkg::SEQ_READ);
			rsp_last_q <= (seq_q == cttm_pkg::SEQ_READ) && (cur_q == end_q);
			rsp_addr_q <= cur_q;
		end
	end

	cttm_exec_mem u_mem (
		.clock(clock),
		.rst(rst),
		.set_en(run_cycle),
		.set_addr(pc),
		.wr_en(seq_q == cttm_pkg::SEQ_WRITE),
		.wr_addr(cur_q),
		.wr_bit(wbit_q),
		.rd_addr(cur_q),
		.rd_bit_q(rsp_bit)
	);

	assign cmd_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_addr = rsp_addr_q;
	assign rsp_last = rsp_last_q;
	assign cycle_count = count_q;
	assign overflow = overflow_q;
	assign counting = counting_q;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_cnt_gate: assert property (!run_cycle && !load_fire |=> $stable(count_q))
		else $error("counter moved outside a counted run cycle");

	chk_cnt_step: assert property (inc_en && !load_fire |=>
		count_q == $past(count_q) + cttm_pkg::CNT_ONE)
		else $error("counter did not advance by one");

	chk_single_start: assert property (run_cycle &&
		start_mode == cttm_pkg::TRIG_SINGLE && pc == start_lo && !stop_hit && !load_fire
		|=> count_q != $past(count_q))
		else $error("single start address did not count");

	chk_range_start: assert property (run_cycle &&
		start_mode == cttm_pkg::TRIG_RANGE && pc >= start_lo && pc <= start_hi && !stop_hit
		|=> counting_q || !run)
		else $error("range start did not gate counting on");

	chk_free_start: assert property (run_cycle && armed_q &&
		start_mode == cttm_pkg::TRIG_FREE && !stop_hit |=> counting_q)
		else $error("free start did not begin with the run");

	chk_keep_start: assert property (set_fire && cmd_start_keep |=>
		$stable(start_mode) && $stable(start_lo) && $stable(start_hi))
		else $error("kept start setting changed");

	chk_stop_excl: assert property (run_cycle && stop_hit && !load_fire |=>
		$stable(count_q) ##0 !counting_q)
		else $error("stop-match cycle was counted");

	chk_range_stop: assert property (run_cycle && stop_mode == cttm_pkg::TRIG_RANGE &&
		pc >= stop_lo && pc <= stop_hi |=> !counting_q)
		else $error("range stop did not end counting");

	chk_free_stop: assert property (counting_q && run &&
		stop_mode == cttm_pkg::TRIG_FREE && !$changed(stop_mode) |=> counting_q || !run)
		else $error("free stop ended counting during the run");

	chk_run_end: assert property (!run |=> !counting_q)
		else $error("counting survived the end of the run");

	chk_cleared_idle: assert property (start_mode == cttm_pkg::TRIG_CLEARED &&
		!counting_q && !load_fire |=> !counting_q && $stable(count_q))
		else $error("cleared triggers let the counter start");

	chk_clear_trig: assert property (clear_fire |=>
		start_mode == cttm_pkg::TRIG_CLEARED && stop_mode == cttm_pkg::TRIG_CLEARED)
		else $error("clear request left a trigger set");

	chk_set_pair: assert property (set_fire && !cmd_start_keep && !cmd_stop_keep |=>
		start_mode == $past(cmd_start_mode) && stop_mode == $past(cmd_stop_mode))
		else $error("trigger pair not applied together");

	chk_read_walk: assert property (bits_fire && cmd_op == cttm_pkg::OP_READ_BITS |=>
		!ready_q ##1 rsp_valid_q && rsp_addr_q == $past(bit_lo, 2))
		else $error("read sweep did not start at the low address");

	chk_busy_hold: assert property (bits_fire |=> !ready_q)
		else $error("host not held off during a sweep");

	chk_wrap_flag: assert property (inc_en && !load_fire &&
		count_q == cttm_pkg::CNT_MAX |=> overflow_q && count_q == cttm_pkg::CNT_RESET)
		else $error("wrap did not raise overflow");

	cov_count_wrap: cover property (inc_en && count_q == cttm_pkg::CNT_MAX);
	cov_range_read: cover property (rsp_last_q && rsp_addr_q != $past(rsp_addr_q, 2));
	cov_stop_hit: cover property (counting_q && run_cycle && stop_hit);
	cov_clear_all: cover property (bits_fire && cmd_all && !cmd_bit_given);

endmodule

// ===== hw/cttm_pkg.sv
// Shared constants, types and helpers for the cycle trigger coverage monitor.
package cttm_pkg;

	localparam int ADDR_W = 12;
	localparam int CNT_W = 32;
	localparam int MEM_DEPTH = 4096;

	typedef logic [ADDR_W-1:0] cttm_addr_t;
	typedef logic [CNT_W-1:0] cttm_cnt_t;

	typedef enum logic [1:0] {
		TRIG_CLEARED = 2'b00,
		TRIG_FREE = 2'b01,
		TRIG_SINGLE = 2'b10,
		TRIG_RANGE = 2'b11
	} cttm_trig_e;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_SET_TRIG = 3'b001,
		OP_CLEAR_TRIG = 3'b010,
		OP_READ_BITS = 3'b011,
		OP_WRITE_BITS = 3'b100,
		OP_LOAD_CNT = 3'b101
	} cttm_op_e;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_READ = 2'b01,
		SEQ_WRITE = 2'b10
	} cttm_seq_e;

	localparam cttm_addr_t ADDR_FIRST = 12'h000;
	localparam cttm_addr_t ADDR_LAST = 12'hFFF;
	localparam cttm_addr_t ADDR_STEP = 12'h001;
	localparam cttm_cnt_t CNT_RESET = 32'h0000_0000;
	localparam cttm_cnt_t CNT_MAX = 32'hFFFF_FFFF;
	localparam cttm_cnt_t CNT_ONE = 32'h0000_0001;
	localparam cttm_trig_e START_RESET = TRIG_FREE;
	localparam cttm_trig_e STOP_RESET = TRIG_FREE;

	// Address match for one trigger; ranges are inclusive at both ends.
	function automatic logic addr_hit(cttm_trig_e mode, cttm_addr_t lo, cttm_addr_t hi,
		cttm_addr_t pc);
		case (mode)
			TRIG_SINGLE: addr_hit = (pc == lo);
			TRIG_RANGE: addr_hit = (pc >= lo) && (pc <= hi);
			default: addr_hit = 1'b0;
		endcase
	endfunction

endpackage

// ===== hw/cttm_trigger.sv
// One programmable trigger: mode and address bounds with its match output.
`timescale 1ns/10ps
module cttm_trigger #(
	parameter cttm_pkg::cttm_trig_e RESET_MODE = cttm_pkg::TRIG_FREE
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic keep,
	input wire logic clear,
	input wire cttm_pkg::cttm_trig_e mode_in,
	input wire cttm_pkg::cttm_addr_t lo_in,
	input wire cttm_pkg::cttm_addr_t hi_in,
	input wire cttm_pkg::cttm_addr_t pc,
	output cttm_pkg::cttm_trig_e mode_q,
	output cttm_pkg::cttm_addr_t lo_q,
	output cttm_pkg::cttm_addr_t hi_q,
	output logic hit
);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_q <= RESET_MODE;
			lo_q <= cttm_pkg::ADDR_FIRST;
			hi_q <= cttm_pkg::ADDR_FIRST;
		end else if (clear) begin
			mode_q <= cttm_pkg::TRIG_CLEARED;
		end else if (load && !keep) begin
			mode_q <= mode_in;
			lo_q <= lo_in;
			hi_q <= hi_in;
		end
	end

	assign hit = cttm_pkg::addr_hit(mode_q, lo_q, hi_q, pc);

endmodule

// ===== verif/cttm_core_model.sv
// Behavioural model of the emulated core that runs code and strobes program addresses.
`timescale 1ns/10ps
module cttm_core_model (
	input wire logic clock,
	input wire logic go,
	input wire cttm_pkg::cttm_addr_t first_pc,
	input wire logic [7:0] n_cyc,
	input wire logic [3:0] gap,
	output logic run,
	output logic cyc_strobe,
	output cttm_pkg::cttm_addr_t pc,
	output logic done
);
	int k;

	////////////////////////////////////////////////////////////////////////////////
	// The address bus shows the inverse of its last value between strobes, so that
	// a monitor that samples it outside a strobe cannot get a lucky match.
	initial begin
		run = 1'b0;
		cyc_strobe = 1'b0;
		pc = 12'h000;
		done = 1'b0;
		forever begin
			@(posedge clock);
			if (go === 1'b1) begin
				run <= 1'b1;
				for (k = 0; k < n_cyc; k++) begin
					@(posedge clock);
					cyc_strobe <= 1'b1;
					pc <= first_pc + k[11:0];
					@(posedge clock);
					cyc_strobe <= 1'b0;
					pc <= ~(first_pc + k[11:0]);
					repeat (gap) @(posedge clock);
				end
				// The last strobe before run falls stands for the break cycle.
				@(posedge clock);
				run <= 1'b0;
				done <= 1'b1;
				@(posedge clock);
				done <= 1'b0;
			end
		end
	end
endmodule

// ===== verif/cttm_monitor_tb.sv
// Self-checking testbench for the cycle trigger coverage monitor.
`timescale 1ns/10ps
module cttm_monitor_tb;
	logic clock, rst, run, cyc_strobe, go, done;
	cttm_pkg::cttm_addr_t pc, first_pc, cmd_lo, cmd_hi, cmd_stop_lo, cmd_stop_hi;
	logic [7:0] n_cyc;
	logic [3:0] gap;
	logic cmd_valid, cmd_start_keep, cmd_stop_keep, cmd_all, cmd_bit, cmd_bit_given;
	cttm_pkg::cttm_op_e cmd_op;
	cttm_pkg::cttm_trig_e cmd_start_mode, cmd_stop_mode, start_mode, stop_mode;
	cttm_pkg::cttm_cnt_t cmd_data, cycle_count;
	logic cmd_ready, rsp_valid, rsp_bit, rsp_last, overflow, counting;
	cttm_pkg::cttm_addr_t rsp_addr, start_lo, start_hi, stop_lo, stop_hi;
	int mismatches, checks_done;
	logic rq[$];

	cttm_core_model core (.clock(clock), .go(go), .first_pc(first_pc), .n_cyc(n_cyc),
		.gap(gap), .run(run), .cyc_strobe(cyc_strobe), .pc(pc), .done(done));

	cttm_monitor uut (.clock(clock), .rst(rst), .run(run), .cyc_strobe(cyc_strobe), .pc(pc),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_lo(cmd_lo), .cmd_hi(cmd_hi),
		.cmd_start_mode(cmd_start_mode), .cmd_start_keep(cmd_start_keep),
		.cmd_stop_mode(cmd_stop_mode), .cmd_stop_keep(cmd_stop_keep),
		.cmd_stop_lo(cmd_stop_lo), .cmd_stop_hi(cmd_stop_hi), .cmd_all(cmd_all),
		.cmd_bit(cmd_bit), .cmd_bit_given(cmd_bit_given), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_bit(rsp_bit),
		.rsp_last(rsp_last), .cycle_count(cycle_count), .overflow(overflow),
		.counting(counting), .start_mode(start_mode), .start_lo(start_lo),
		.start_hi(start_hi), .stop_mode(stop_mode), .stop_lo(stop_lo), .stop_hi(stop_hi));

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask

	// Ready is sampled mid-cycle so the following rising edge sees a settled value.
	task automatic wait_ready;
		int i;
		for (i = 0; i < 5000; i++) begin
			@(negedge clock);
			if (cmd_ready === 1'b1)
				return;
		end
		mismatches++;
		print_verdict();
	endtask

	task automatic send(input cttm_pkg::cttm_op_e op);
		wait_ready();
		@(posedge clock);
		cmd_op <= op;
		cmd_valid <= 1'b1;
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask

	task automatic settle;
		repeat (2) @(negedge clock);
	endtask

	// Fields change on a rising edge, at least one edge ahead of the strobe that sends them.
	task automatic trig(input cttm_pkg::cttm_trig_e sm, input cttm_pkg::cttm_addr_t slo, shi,
		input logic sk, input cttm_pkg::cttm_trig_e pm, input cttm_pkg::cttm_addr_t plo, phi,
		input logic pk);
		@(posedge clock);
		cmd_start_mode <= sm;
		cmd_lo <= slo;
		cmd_hi <= shi;
		cmd_start_keep <= sk;
		cmd_stop_mode <= pm;
		cmd_stop_lo <= plo;
		cmd_stop_hi <= phi;
		cmd_stop_keep <= pk;
		send(cttm_pkg::OP_SET_TRIG);
	endtask

	task automatic load(input cttm_pkg::cttm_cnt_t v);
		@(posedge clock);
		cmd_data <= v;
		send(cttm_pkg::OP_LOAD_CNT);
	endtask

	// Read responses are gathered in order and their addresses checked on the fly.
	task automatic bits(input cttm_pkg::cttm_op_e op, input cttm_pkg::cttm_addr_t lo, hi,
		input logic all, b, given);
		int i;
		cttm_pkg::cttm_addr_t a;
		@(posedge clock);
		a = all ? 12'h000 : lo;
		cmd_lo <= lo;
		cmd_hi <= hi;
		cmd_all <= all;
		cmd_bit <= b;
		cmd_bit_given <= given;
		send(op);
		rq.delete();
		if (op != cttm_pkg::OP_READ_BITS)
			return;
		for (i = 0; i < 5000; i++) begin
			@(negedge clock);
			if (rsp_valid === 1'b1) begin
				chk("rsp_addr", a, rsp_addr);
				a = a + 12'h001;
				rq.push_back(rsp_bit);
				if (rsp_last === 1'b1)
					return;
			end
		end
		mismatches++;
		print_verdict();
	endtask

	task automatic exec(input cttm_pkg::cttm_addr_t f, input logic [7:0] n,
		input logic [3:0] g);
		int i;
		wait_ready();
		@(posedge clock);
		first_pc <= f;
		n_cyc <= n;
		gap <= g;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		for (i = 0; i < 5000; i++) begin
			@(negedge clock);
			if (done === 1'b1)
				break;
		end
		if (i == 5000) begin
			mismatches++;
			print_verdict();
		end
		settle();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_free;
		chk("start_mode", cttm_pkg::TRIG_FREE, start_mode);
		chk("stop_mode", cttm_pkg::TRIG_FREE, stop_mode);
		exec(12'h020, 8'h05, 4'h1);
		chk("cycle_count", 32'h0000_0005, cycle_count);
		chk("counting", 32'h0000_0000, counting);
		$display("Test free run done");
	endtask

	task automatic t_single;
		trig(cttm_pkg::TRIG_SINGLE, 12'h105, 12'h105, 1'b0, cttm_pkg::TRIG_SINGLE,
			12'h108, 12'h108, 1'b0);
		load(32'h0000_0000);
		exec(12'h100, 8'h0C, 4'h0);
		chk("cycle_count", 32'h0000_0003, cycle_count);
		$display("Test single triggers done");
	endtask

	// Each half of a set may keep its old setting while the other half changes.
	task automatic t_range;
		trig(cttm_pkg::TRIG_RANGE, 12'h200, 12'h202, 1'b0, cttm_pkg::TRIG_RANGE,
			12'h205, 12'h206, 1'b0);
		load(32'h0000_0000);
		exec(12'h1FE, 8'h0A, 4'h2);
		chk("cycle_count", 32'h0000_0005, cycle_count);
		chk("start_lo", 32'h0000_0200, start_lo);
		chk("stop_lo", 32'h0000_0205, stop_lo);
		chk("stop_hi", 32'h0000_0206, stop_hi);
		trig(cttm_pkg::TRIG_SINGLE, 12'h000, 12'h000, 1'b1, cttm_pkg::TRIG_FREE,
			12'h000, 12'h000, 1'b0);
		settle();
		chk("start_mode", cttm_pkg::TRIG_RANGE, start_mode);
		chk("start_hi", 32'h0000_0202, start_hi);
		chk("stop_mode", cttm_pkg::TRIG_FREE, stop_mode);
		chk("stop_lo", 32'h0000_0000, stop_lo);
		trig(cttm_pkg::TRIG_SINGLE, 12'h300, 12'h300, 1'b0, cttm_pkg::TRIG_RANGE,
			12'h001, 12'h002, 1'b1);
		settle();
		chk("start_mode", cttm_pkg::TRIG_SINGLE, start_mode);
		chk("start_lo", 32'h0000_0300, start_lo);
		chk("stop_mode", cttm_pkg::TRIG_FREE, stop_mode);
		chk("stop_hi", 32'h0000_0000, stop_hi);
		$display("Test range and keep done");
	endtask

	task automatic t_clear;
		send(cttm_pkg::OP_CLEAR_TRIG);
		settle();
		chk("start_mode", cttm_pkg::TRIG_CLEARED, start_mode);
		chk("stop_mode", cttm_pkg::TRIG_CLEARED, stop_mode);
		load(32'h0000_0000);
		exec(12'h000, 8'h04, 4'h0);
		chk("cycle_count", 32'h0000_0000, cycle_count);
		$display("Test clear done");
	endtask

	task automatic t_wrap;
		trig(cttm_pkg::TRIG_FREE, 12'h000, 12'h000, 1'b0, cttm_pkg::TRIG_FREE,
			12'h000, 12'h000, 1'b0);
		load(32'hFFFF_FFFE);
		exec(12'h000, 8'h03, 4'h0);
		chk("cycle_count", 32'h0000_0001, cycle_count);
		chk("overflow", 32'h0000_0001, overflow);
		load(32'h0000_0007);
		settle();
		chk("overflow", 32'h0000_0000, overflow);
		$display("Test wrap done");
	endtask

	task automatic t_bits;
		int i, ones;
		bits(cttm_pkg::OP_WRITE_BITS, 12'h000, 12'h000, 1'b1, 1'b1, 1'b0);
		bits(cttm_pkg::OP_WRITE_BITS, 12'h010, 12'h01F, 1'b0, 1'b1, 1'b1);
		bits(cttm_pkg::OP_WRITE_BITS, 12'h014, 12'h014, 1'b0, 1'b0, 1'b1);
		exec(12'h020, 8'h02, 4'h0);
		bits(cttm_pkg::OP_READ_BITS, 12'h012, 12'h023, 1'b0, 1'b0, 1'b0);
		chk("read size", 32'h0000_0012, rq.size());
		for (i = 0; i < rq.size(); i++)
			chk("exec bit", ((i != 2) && (i < 16)), rq[i]);
		bits(cttm_pkg::OP_READ_BITS, 12'h000, 12'h000, 1'b1, 1'b0, 1'b0);
		chk("full size", 32'h0000_1000, rq.size());
		ones = 0;
		foreach (rq[j])
			ones += (rq[j] === 1'b1);
		chk("ones", 32'h0000_0011, ones);
		$display("Test bit memory done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		rst = 1'b1;
		go = 1'b0;
		first_pc = 12'h000;
		n_cyc = 8'h00;
		gap = 4'h0;
		cmd_valid = 1'b0;
		cmd_op = cttm_pkg::OP_NONE;
		cmd_lo = 12'h000;
		cmd_hi = 12'h000;
		cmd_start_mode = cttm_pkg::TRIG_FREE;
		cmd_start_keep = 1'b0;
		cmd_stop_mode = cttm_pkg::TRIG_FREE;
		cmd_stop_keep = 1'b0;
		cmd_stop_lo = 12'h000;
		cmd_stop_hi = 12'h000;
		cmd_all = 1'b0;
		cmd_bit = 1'b0;
		cmd_bit_given = 1'b0;
		cmd_data = 32'h0000_0000;
		mismatches = 0;
		checks_done = 0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_free();
		t_single();
		t_range();
		t_clear();
		t_wrap();
		t_bits();
		print_verdict();
	end
endmodule
